// ### verilog/decode_pkg.sv
package decode_pkg;
	// ==========================================
	// Register word indices
	localparam logic [3:0] REG_MEM_BASE = 4'h0;
	localparam logic [3:0] REG_MEM_LIMIT = 4'h1;
	localparam logic [3:0] REG_PREF_BASE = 4'h2;
	localparam logic [3:0] REG_PREF_LIMIT = 4'h3;
	localparam logic [3:0] REG_TOLM = 4'h4;
	localparam logic [3:0] REG_APER_BASE = 4'h5;
	localparam logic [3:0] REG_APER_SIZE = 4'h6;
	localparam logic [3:0] REG_SMM_CTRL = 4'h7;
	localparam logic [3:0] REG_IO_BASE = 4'h8;
	localparam logic [3:0] REG_IO_LIMIT = 4'h9;
	localparam logic [3:0] REG_STATUS = 4'hA;
	// ==========================================
	// Control field positions
	localparam int SMM_EN_BIT = 0;
	localparam int SMM_OPEN_BIT = 1;
	localparam int SMM_CLOSE_BIT = 2;
	localparam int HIGH_EN_BIT = 3;
	localparam int TOP_EN_BIT = 4;
	localparam int TOP_SEG_SIZE_LSB = 5;
	// ==========================================
	// Reset values and the aperture size limit
	localparam logic [31:0] BASE_RST = 32'hFFFF_FFFF;
	localparam logic [31:0] LIMIT_RST = 32'h0000_0000;
	localparam logic [31:0] TOLM_RST = 32'h0400_0000;
	localparam logic [2:0] APER_SEL_RST = 3'h6;
	localparam logic [2:0] APER_SEL_MAX = 3'h6;
	localparam logic [15:0] IO_BASE_RST = 16'hFFFF;
	localparam logic [15:0] IO_LIMIT_RST = 16'h0000;
	// ==========================================
	// Fixed address ranges
	localparam logic [31:0] COMPAT_LO = 32'h000A_0000;
	localparam logic [31:0] COMPAT_HI = 32'h000B_FFFF;
	localparam logic [31:0] HIGH_LO = 32'hFEDA_0000;
	localparam logic [31:0] HIGH_HI = 32'hFEDB_FFFF;
	localparam logic [31:0] HIGH_REMAP = 32'hFED0_0000;
	localparam logic [31:0] APER_MIN = 32'h0040_0000;
	localparam logic [31:0] TOP_SMM_REGION_MIN = 32'h0002_0000;
	localparam logic [15:0] CFG_ADDR_PORT = 16'h0CF8;
	localparam logic [15:0] CFG_DATA_PORT = 16'h0CFC;
	// ==========================================
	// Types
	typedef enum logic [1:0] {
		SRC_CPU = 2'b00, SRC_HUB = 2'b01, SRC_AGP = 2'b10
	} source_t;
	typedef enum logic [2:0] {
		K_MRD = 3'b000, K_MWR = 3'b001, K_IORD = 3'b010,
		K_IOWR = 3'b011, K_CFGRD = 3'b100, K_CFGWR = 3'b101
	} kind_t;
	typedef enum logic [2:0] {
		R_NONE = 3'b000, R_DRAM = 3'b001, R_AGP = 3'b010,
		R_HUB = 3'b011, R_INT = 3'b100
	} route_t;
	typedef struct packed {
		logic valid;
		source_t source;
		kind_t kind;
		logic [31:0] addr;
		logic io_wrap;
		logic smm_code;
		logic needs_cpl;
		logic ide;
	} req_t;
	typedef struct packed {
		logic valid;
		route_t route;
		logic [31:0] addr;
		logic translate;
		logic special;
		logic master_abort;
		logic posted;
	} resp_t;
endpackage

// ### verilog/system_address_decoder.sv
`timescale 1ns/1ps
module system_address_decoder (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// Register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// Transaction decode
	input decode_pkg::req_t req_in,
	output decode_pkg::resp_t resp_out
);
	import decode_pkg::*;

	// ==========================================
	// Configuration registers
	logic [31:0] mem_base_q;
	logic [31:0] mem_limit_q;
	logic [31:0] pref_base_q;
	logic [31:0] pref_limit_q;
	logic [31:0] tolm_q;
	logic [31:0] aper_base_q;
	logic [2:0] aper_sel_q;
	logic [6:0] smm_ctrl_q;
	logic [15:0] io_base_q;
	logic [15:0] io_limit_q;
	logic [31:0] aper_size;
	logic [31:0] aper_mask;
	logic [31:0] top_smm_region_size;

	assign aper_size = APER_MIN << aper_sel_q;
	assign aper_mask = ~(aper_size - 32'h0000_0001);
	assign top_smm_region_size = TOP_SMM_REGION_MIN << smm_ctrl_q[TOP_SEG_SIZE_LSB +: 2];

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			mem_base_q <= BASE_RST;
			mem_limit_q <= LIMIT_RST;
			pref_base_q <= BASE_RST;
			pref_limit_q <= LIMIT_RST;
			tolm_q <= TOLM_RST;
			aper_base_q <= '0;
			aper_sel_q <= APER_SEL_RST;
			smm_ctrl_q <= '0;
			io_base_q <= IO_BASE_RST;
			io_limit_q <= IO_LIMIT_RST;
		end else if (reg_wr_in) begin
			unique case (reg_addr_in)
				REG_MEM_BASE: mem_base_q <= reg_wdata_in;
				REG_MEM_LIMIT: mem_limit_q <= reg_wdata_in;
				REG_PREF_BASE: pref_base_q <= reg_wdata_in;
				REG_PREF_LIMIT: pref_limit_q <= reg_wdata_in;
				REG_TOLM: tolm_q <= reg_wdata_in;
				// Low bits dropped on write and masked again on use
				REG_APER_BASE: aper_base_q <= reg_wdata_in & aper_mask;
				REG_APER_SIZE: begin
					// Only seven sizes exist; an out-of-range code clamps
					if (reg_wdata_in[2:0] > APER_SEL_MAX) begin
						aper_sel_q <= APER_SEL_MAX;
					end else begin
						aper_sel_q <= reg_wdata_in[2:0];
					end
				end
				REG_SMM_CTRL: smm_ctrl_q <= reg_wdata_in[6:0];
				REG_IO_BASE: io_base_q <= reg_wdata_in[15:0];
				REG_IO_LIMIT: io_limit_q <= reg_wdata_in[15:0];
				default: ;
			endcase
		end
	end

	// ==========================================
	// Range hits
	logic [31:0] a;
	logic [31:0] aper_lo;
	logic [31:0] top_smm_region_lo;
	logic cpu;
	logic is_mem;
	logic is_io;
	logic is_cfg;
	logic is_wr;
	logic smm_en;
	logic smm_ok;
	logic compat_hit;
	logic high_hit;
	logic top_smm_region_hit;
	logic aper_hit;
	logic win_hit;
	logic below_tolm;
	logic cfg_port;
	logic agp_io;

	assign a = req_in.addr;
	assign cpu = (req_in.source == SRC_CPU);
	assign is_mem = (req_in.kind == K_MRD) || (req_in.kind == K_MWR);
	assign is_io = (req_in.kind == K_IORD) || (req_in.kind == K_IOWR);
	assign is_cfg = (req_in.kind == K_CFGRD) || (req_in.kind == K_CFGWR);
	assign is_wr = (req_in.kind == K_MWR) || (req_in.kind == K_IOWR);
	assign smm_en = smm_ctrl_q[SMM_EN_BIT];
	// Code fetches in SMM always pass; data needs the open window
	assign smm_ok = cpu && smm_en && (req_in.smm_code ||
		(smm_ctrl_q[SMM_OPEN_BIT] && !smm_ctrl_q[SMM_CLOSE_BIT]));
	assign compat_hit = smm_en && (a >= COMPAT_LO) && (a <= COMPAT_HI);
	assign high_hit = smm_en && smm_ctrl_q[HIGH_EN_BIT] &&
		(a >= HIGH_LO) && (a <= HIGH_HI);
	assign top_smm_region_lo = tolm_q - top_smm_region_size;
	assign top_smm_region_hit = smm_en && smm_ctrl_q[TOP_EN_BIT] &&
		(a >= top_smm_region_lo) && (a < tolm_q);
	assign aper_lo = aper_base_q & aper_mask;
	assign aper_hit = ((a & aper_mask) == aper_lo);
	assign win_hit = ((a >= mem_base_q) && (a <= mem_limit_q)) ||
		((a >= pref_base_q) && (a <= pref_limit_q));
	assign below_tolm = (a < tolm_q);
	assign cfg_port = (a[15:2] == CFG_ADDR_PORT[15:2]) ||
		(a[15:2] == CFG_DATA_PORT[15:2]);
	assign agp_io = (a[15:0] >= io_base_q) && (a[15:0] <= io_limit_q);

	// ==========================================
	// Destination decode
	resp_t resp_d;

	always_comb begin
		resp_d = '0;
		resp_d.valid = req_in.valid;
		resp_d.addr = a;
		if (!req_in.valid) begin
			resp_d.addr = '0;
		end else if (is_io || is_cfg) begin
			if (!cpu || is_cfg) begin
				// Left unclaimed; a hub request may still need a completion
				resp_d.route = R_NONE;
				resp_d.master_abort = (req_in.source == SRC_HUB) &&
					req_in.needs_cpl;
				resp_d.addr = '0;
			end else begin
				resp_d.addr = {15'h0000, req_in.io_wrap, a[15:0]};
				resp_d.posted = is_wr && !req_in.ide;
				if (cfg_port) begin
					resp_d.route = R_INT;
				end else if (agp_io) begin
					resp_d.route = R_AGP;
				end else begin
					resp_d.route = R_HUB;
				end
			end
		end else if (is_mem) begin
			resp_d.posted = is_wr;
			if ((compat_hit || high_hit || top_smm_region_hit) && !cpu) begin
				// Reads see location 0, writes vanish
				resp_d.special = 1'b1;
				resp_d.route = is_wr ? R_NONE : R_DRAM;
				resp_d.addr = '0;
				resp_d.posted = 1'b0;
			end else if (compat_hit) begin
				// Processor traffic here without smm_ok is legacy video
				resp_d.route = smm_ok ? R_DRAM : R_HUB;
			end else if (high_hit && smm_ok) begin
				resp_d.route = R_DRAM;
				resp_d.addr = a - HIGH_REMAP;
			end else if (top_smm_region_hit) begin
				resp_d.special = !smm_ok;
				if (smm_ok) begin
					resp_d.route = R_DRAM;
				end else begin
					resp_d.route = is_wr ? R_NONE : R_DRAM;
					resp_d.addr = '0;
					resp_d.posted = 1'b0;
				end
			end else if (aper_hit) begin
				// Table walk happens downstream; offset is passed
				resp_d.route = R_DRAM;
				resp_d.translate = 1'b1;
				resp_d.addr = a & ~aper_mask;
			end else if (win_hit) begin
				resp_d.route = R_AGP;
			end else if (below_tolm) begin
				resp_d.route = R_DRAM;
			end else begin
				resp_d.route = R_HUB;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			resp_out <= '0;
		end else begin
			resp_out <= resp_d;
		end
	end

	// ==========================================
	// Status: last routed decision, for software
	logic [7:0] status_q;

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			status_q <= '0;
		end else if (req_in.valid) begin
			status_q <= {resp_d.master_abort, resp_d.special,
				resp_d.translate, resp_d.posted, 1'b0, resp_d.route};
		end
	end

	// ==========================================
	// Register read port
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			reg_rdata_out <= '0;
		end else if (reg_rd_in) begin
			unique case (reg_addr_in)
				REG_MEM_BASE: reg_rdata_out <= mem_base_q;
				REG_MEM_LIMIT: reg_rdata_out <= mem_limit_q;
				REG_PREF_BASE: reg_rdata_out <= pref_base_q;
				REG_PREF_LIMIT: reg_rdata_out <= pref_limit_q;
				REG_TOLM: reg_rdata_out <= tolm_q;
				REG_APER_BASE: reg_rdata_out <= aper_lo;
				REG_APER_SIZE: reg_rdata_out <= {29'h0, aper_sel_q};
				REG_SMM_CTRL: reg_rdata_out <= {25'h0, smm_ctrl_q};
				REG_IO_BASE: reg_rdata_out <= {16'h0000, io_base_q};
				REG_IO_LIMIT: reg_rdata_out <= {16'h0000, io_limit_q};
				REG_STATUS: reg_rdata_out <= {24'h0, status_q};
				default: reg_rdata_out <= '0;
			endcase
		end else begin
			reg_rdata_out <= '0;
		end
	end

	// ==========================================
	// Assertions
	logic v_mem;
	logic smm_any;

	assign v_mem = req_in.valid && is_mem;
	assign smm_any = compat_hit || high_hit || top_smm_region_hit;

	a_agp_window: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		v_mem && !smm_any && !aper_hit && win_hit
		|=> resp_out.route == R_AGP)
		else $error("AGP window hit not routed to AGP");

	a_subtractive_hub: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		v_mem && !smm_any && !aper_hit && !win_hit && !below_tolm
		|=> resp_out.route == R_HUB && !resp_out.special)
		else $error("Unmatched high memory not sent to hub");

	a_aperture_dram: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		v_mem && !smm_any && aper_hit
		|=> resp_out.route == R_DRAM && resp_out.translate)
		else $error("Aperture hit not translated to DRAM");

	a_aper_align: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		reg_rd_in && reg_addr_in == REG_APER_BASE
		|=> (reg_rdata_out & ~$past(aper_mask)) == 32'h0000_0000)
		else $error("Aperture base low bits not zero");

	a_smm_blocked: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		v_mem && !cpu && smm_any
		|=> resp_out.special && resp_out.addr == 32'h0000_0000)
		else $error("Non-processor SMM access not blocked");

	a_smm_wr_drop: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		v_mem && is_wr && !cpu && smm_any
		|=> resp_out.route == R_NONE && !resp_out.posted)
		else $error("Blocked SMM write not dropped");

	a_high_remap: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		v_mem && high_hit && smm_ok
		|=> resp_out.addr == $past(a) - HIGH_REMAP)
		else $error("High SMM address not remapped");

	a_io_passthru: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		req_in.valid && is_io && cpu
		|=> resp_out.addr[16:0] == {$past(req_in.io_wrap), $past(a[15:0])})
		else $error("I/O address altered");

	a_io_unclaimed: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		req_in.valid && (is_io || is_cfg) && !cpu
		|=> resp_out.route == R_NONE)
		else $error("Foreign I/O or config cycle claimed");

	a_ide_not_posted: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		req_in.valid && req_in.kind == K_IOWR && req_in.ide
		|=> !resp_out.posted)
		else $error("IDE I/O write posted");

	c_agp_route: cover property (@(posedge clk_in)
		disable iff (!reset_n_in) resp_out.valid && resp_out.route == R_AGP);
	c_translate: cover property (@(posedge clk_in)
		disable iff (!reset_n_in) resp_out.valid && resp_out.translate);
	c_special: cover property (@(posedge clk_in)
		disable iff (!reset_n_in) resp_out.valid && resp_out.special);
	c_abort: cover property (@(posedge clk_in)
		disable iff (!reset_n_in) resp_out.master_abort);
endmodule // system_address_decoder

// ### tb/bus_agent.sv
`timescale 1ns/1ps
// ==========================================
// Requesting agent model: processor, hub or AGP master
module bus_agent (
	// Clock
	input wire logic clk_in,
	// Request toward the decoder
	output decode_pkg::req_t req_out
);
	import decode_pkg::*;

	initial req_out = '0;

	// One request per call; the bus is left scrambled once released
	task automatic issue(input source_t s, input kind_t k,
		input logic [31:0] a, input int unsigned n, input logic smm,
		input logic cpl, input logic ide);
		req_t r;
		req_t idle;
		r = '0;
		r.valid = 1'b1;
		r.source = s;
		r.kind = k;
		r.addr = a;
		r.smm_code = smm;
		r.needs_cpl = cpl;
		r.ide = ide;
		// Wrap bit for any I/O access that runs past the top port
		r.io_wrap = ((k == K_IORD) || (k == K_IOWR)) &&
			(({16'h0000, a[15:0]} + n) > 32'h0001_0000);
		idle = ~r;
		idle.valid = 1'b0;
		@(posedge clk_in);
		req_out <= r;
		@(posedge clk_in);
		req_out <= idle;
	endtask
endmodule // bus_agent

// ### tb/system_address_decoder_bench.sv
`timescale 1ns/1ps
module system_address_decoder_bench;
	import decode_pkg::*;

	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic [3:0] reg_addr_in = 4'h0;
	logic [31:0] reg_wdata_in = 32'h0000_0000;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [31:0] reg_rdata_out;
	req_t req;
	resp_t resp;
	int error_cnt = 0;
	int comparisons = 0;

	system_address_decoder uut (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out),
		.req_in(req),
		.resp_out(resp)
	);

	bus_agent agent (
		.clk_in(clk_in),
		.req_out(req)
	);

	// ==========================================
	// Clock and shared tasks
	initial begin
		forever #20 clk_in = ~clk_in;
	end

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1;
		check("reg_rdata", reg_rdata_out, e);
	endtask

	// Flags are {translate, special, master_abort, posted}
	task automatic rq(input source_t s, input kind_t k,
		input logic [31:0] a, input int unsigned n, input logic [2:0] m,
		input route_t er, input logic [31:0] ea, input logic [3:0] ef);
		agent.issue(s, k, a, n, m[2], m[1], m[0]);
		#1;
		check("valid", {31'h0, resp.valid}, 32'h1);
		check("route", {29'h0, resp.route}, {29'h0, er});
		check("addr", resp.addr, ea);
		check("flags", {28'h0, resp.translate, resp.special,
			resp.master_abort, resp.posted}, {28'h0, ef});
	endtask

	// ==========================================
	// Scenarios
	task automatic t_regs();
		rd_chk(REG_APER_SIZE, 32'h0000_0006);
		rd_chk(REG_TOLM, TOLM_RST);
		rd_chk(4'hB, 32'h0000_0000);
		wr(REG_APER_SIZE, 32'h0000_0007);
		rd_chk(REG_APER_SIZE, 32'h0000_0006);
		wr(REG_APER_SIZE, 32'h0000_0000);
		wr(REG_APER_BASE, 32'hE012_3456);
		rd_chk(REG_APER_BASE, 32'hE000_0000);
		$display("test regs done");
	endtask

	task automatic t_mem();
		// Windows sit above low-memory top and apart from the aperture
		wr(REG_MEM_BASE, 32'h8000_0000);
		wr(REG_MEM_LIMIT, 32'h80FF_FFFF);
		wr(REG_PREF_BASE, 32'h9000_0000);
		wr(REG_PREF_LIMIT, 32'h9000_0FFF);
		rq(SRC_CPU, K_MRD, 32'h8000_0000, 1, 3'h0, R_AGP, 32'h8000_0000,
			4'h0);
		rq(SRC_CPU, K_MWR, 32'h80FF_FFFF, 1, 3'h0, R_AGP, 32'h80FF_FFFF,
			4'h1);
		rq(SRC_CPU, K_MRD, 32'h9000_0FFF, 1, 3'h0, R_AGP, 32'h9000_0FFF,
			4'h0);
		rq(SRC_CPU, K_MRD, 32'h9000_1000, 1, 3'h0, R_HUB, 32'h9000_1000,
			4'h0);
		rq(SRC_CPU, K_MRD, 32'h0400_0000, 1, 3'h0, R_HUB, 32'h0400_0000,
			4'h0);
		rq(SRC_CPU, K_MRD, 32'h03FF_FFFF, 1, 3'h0, R_DRAM, 32'h03FF_FFFF,
			4'h0);
		rq(SRC_CPU, K_MRD, 32'hE03F_1234, 1, 3'h0, R_DRAM, 32'h003F_1234,
			4'h8);
		rq(SRC_CPU, K_MRD, 32'hE040_0000, 1, 3'h0, R_HUB, 32'hE040_0000,
			4'h0);
		$display("test mem done");
	endtask

	task automatic t_smm();
		// Enable, high and top segments; open and close never together;
		// segments kept clear of other spaces
		wr(REG_SMM_CTRL, 32'h0000_0019);
		rq(SRC_CPU, K_MRD, 32'h000A_0000, 1, 3'h4, R_DRAM, 32'h000A_0000,
			4'h0);
		rq(SRC_CPU, K_MRD, 32'h000B_FFFF, 1, 3'h0, R_HUB, 32'h000B_FFFF,
			4'h0);
		rq(SRC_CPU, K_MRD, 32'hFEDA_1234, 1, 3'h4, R_DRAM, 32'h000A_1234,
			4'h0);
		rq(SRC_HUB, K_MRD, 32'hFEDA_1234, 1, 3'h4, R_DRAM, 32'h0000_0000,
			4'h4);
		rd_chk(REG_STATUS, 32'h0000_0041);
		rq(SRC_AGP, K_MWR, 32'h000A_0000, 1, 3'h0, R_NONE, 32'h0000_0000,
			4'h4);
		rq(SRC_CPU, K_MRD, 32'h03FE_0000, 1, 3'h4, R_DRAM, 32'h03FE_0000,
			4'h0);
		rq(SRC_HUB, K_MRD, 32'h03FF_FFFF, 1, 3'h0, R_DRAM, 32'h0000_0000,
			4'h4);
		rq(SRC_HUB, K_MRD, 32'h03FD_FFFF, 1, 3'h0, R_DRAM, 32'h03FD_FFFF,
			4'h0);
		wr(REG_SMM_CTRL, 32'h0000_001B);
		rq(SRC_CPU, K_MRD, 32'h000A_0000, 1, 3'h0, R_DRAM, 32'h000A_0000,
			4'h0);
		// Largest top segment, 1 MB, just below low-memory top
		wr(REG_SMM_CTRL, 32'h0000_0071);
		rq(SRC_HUB, K_MRD, 32'h03F0_0000, 1, 3'h0, R_DRAM, 32'h0000_0000,
			4'h4);
		rq(SRC_HUB, K_MRD, 32'h03EF_FFFF, 1, 3'h0, R_DRAM, 32'h03EF_FFFF,
			4'h0);
		$display("test smm done");
	endtask

	task automatic t_io();
		wr(REG_IO_BASE, 32'h0000_1000);
		wr(REG_IO_LIMIT, 32'h0000_10FF);
		rq(SRC_CPU, K_IORD, 32'h0000_1000, 1, 3'h0, R_AGP, 32'h0000_1000,
			4'h0);
		rq(SRC_CPU, K_IORD, 32'h0000_10FF, 1, 3'h0, R_AGP, 32'h0000_10FF,
			4'h0);
		rq(SRC_CPU, K_IORD, 32'h0000_1100, 1, 3'h0, R_HUB, 32'h0000_1100,
			4'h0);
		rq(SRC_CPU, K_IORD, 32'h0000_0CF8, 4, 3'h0, R_INT, 32'h0000_0CF8,
			4'h0);
		rq(SRC_CPU, K_IOWR, 32'h0000_FFFE, 4, 3'h0, R_HUB, 32'h0001_FFFE,
			4'h1);
		rq(SRC_CPU, K_IORD, 32'h0000_FFFE, 2, 3'h0, R_HUB, 32'h0000_FFFE,
			4'h0);
		rq(SRC_CPU, K_IOWR, 32'h0000_01F0, 2, 3'h1, R_HUB, 32'h0000_01F0,
			4'h0);
		rq(SRC_HUB, K_IOWR, 32'h0000_1000, 1, 3'h2, R_NONE, 32'h0000_0000,
			4'h2);
		rq(SRC_HUB, K_IOWR, 32'h0000_0200, 1, 3'h0, R_NONE, 32'h0000_0000,
			4'h0);
		rq(SRC_HUB, K_CFGRD, 32'h0000_0CFC, 4, 3'h2, R_NONE, 32'h0000_0000,
			4'h2);
		rd_chk(REG_STATUS, 32'h0000_0080);
		rq(SRC_HUB, K_CFGWR, 32'h0000_0CFC, 4, 3'h0, R_NONE, 32'h0000_0000,
			4'h0);
		rq(SRC_AGP, K_IORD, 32'h0000_1000, 1, 3'h0, R_NONE, 32'h0000_0000,
			4'h0);
		$display("test io done");
	endtask

	// ==========================================
	// Verdict, sequence and watchdog
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge clk_in);
		reset_n_in <= 1'b1;
		t_regs();
		t_mem();
		t_smm();
		t_io();
		tally_and_finish();
	end

	// Whole run needs about a hundred cycles; allow ample margin
	initial begin
		#(40 * 5000);
		error_cnt++;
		tally_and_finish();
	end
endmodule // system_address_decoder_bench
